// file: verification/tpcr_regs_tb.sv
// Self-checking bench of the PMA/PCS register bank.
// Assumes tpcr_sme_model as the APB master and the bench driving idle conditions.
`timescale 1ns/100ps
`include "tpcr_defines.svh"
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected %s: expected %h, seen %h", what, exp, got); end end

module tpcr_regs_tb;
   logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [15:0]               paddr;
   logic [31:0]               pwdata, prdata;
   tpcr_pkg::tpcr_lpi_in_type lpi_in;
   logic                      link_role_select, soft_rst, loop_en, rx_stop, irq;
   logic                      package_36_pin, indicator_zero_strap, receive_bit_three_strap;
   logic [2:0]                test_mode_select;
   int                        miscompares, n_compared, n_srst;

   // ****************************************************************
   // Clock, reset and instances
   // ****************************************************************
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      if (soft_rst === 1'b1) n_srst <= n_srst + 1;
   end

   tpcr_sme_model sme_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   // Straps start as package 36 with the indicator strap high, which gives master at reset.
   tpcr_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .package_36_pin(package_36_pin),
      .indicator_zero_strap(indicator_zero_strap),
      .receive_bit_three_strap(receive_bit_three_strap), .lpi_in(lpi_in),
      .link_role_select(link_role_select),
      .test_mode_select(test_mode_select), .coding_sublayer_soft_reset(soft_rst),
      .coding_sublayer_loop_enable(loop_en), .receive_clock_stop_allowed(rx_stop),
      .irq(irq));

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      logic ok;
      sme_u.xfer(wr, {idx, 2'h0}, wd, rd, err, ok);
      if (ok !== 1'b1) begin
         miscompares++;
         $display("unexpected pready: expected 1, seen 0");
         stop_test();
      end
   endtask

   task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      logic        err;
      bus(1'b1, idx, wd, rd, err);
   endtask

   task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      bus(1'b0, idx, 32'h00000000, rd, err);
      `CHK("read data", exp, rd);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   task automatic drive(input logic [2:0] v);
      @(posedge pclk);
      lpi_in <= tpcr_pkg::tpcr_lpi_in_type'(v);
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset;
      logic [31:0] rd;
      logic        err;
      rd_chk(`TPCR_IDX_ROLE, 32'h0000C000);
      `CHK("role", 1'b1, link_role_select);
      rd_chk(`TPCR_IDX_TEST, 32'h00000000);
      rd_chk(`TPCR_IDX_CTRL1, 32'h00000400);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000000);
      bus(1'b0, 14'h0000, 32'h00000000, rd, err);
      `CHK("unmapped err", 1'b1, err);
      `CHK("unmapped data", 32'h00000000, rd);
      $display("test reset done");
   endtask

   task automatic t_role;
      wr(`TPCR_IDX_ROLE, 32'h00000000);
      settle(1);
      `CHK("role", 1'b0, link_role_select);
      rd_chk(`TPCR_IDX_ROLE, 32'h00008000);
      wr(`TPCR_IDX_ROLE, 32'h0000400F);
      settle(1);
      `CHK("role", 1'b1, link_role_select);
      rd_chk(`TPCR_IDX_ROLE, 32'h0000C000);
      $display("test role done");
   endtask

   task automatic t_test;
      logic [2:0] m;
      for (int c = 0; c < 8; c++) begin
         m = (c == 3 || c > 5) ? 3'h0 : 3'(c);
         wr(`TPCR_IDX_TEST, {16'h0000, 3'(c), 13'h1ABC});
         rd_chk(`TPCR_IDX_TEST, {16'h0000, 3'(c), 13'h1ABC});
         `CHK("test mode", m, test_mode_select);
      end
      $display("test modes done");
   endtask

   task automatic t_soft;
      wr(`TPCR_IDX_CTRL1, 32'h00004000);
      settle(1);
      `CHK("loop", 1'b1, loop_en);
      rd_chk(`TPCR_IDX_CTRL1, 32'h00004000);
      `CHK("soft pulses", 0, n_srst);
      wr(`TPCR_IDX_CTRL1, 32'h0000C000);
      settle(2);
      `CHK("loop", 1'b0, loop_en);
      `CHK("soft pulses", 1, n_srst);
      rd_chk(`TPCR_IDX_CTRL1, 32'h00000400);
      $display("test soft reset done");
   endtask

   task automatic t_lpi;
      drive(3'b101);
      drive(3'b101);
      drive(3'b001);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000840);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000040);
      drive(3'b111);
      settle(3);
      `CHK("rx stop", 1'b1, rx_stop);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000F40);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000F40);
      wr(`TPCR_IDX_CTRL1, 32'h00000000);
      settle(2);
      `CHK("rx stop", 1'b0, rx_stop);
      drive(3'b000);
      settle(2);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000C00);
      rd_chk(`TPCR_IDX_STAT1, 32'h00000000);
      `CHK("irq masked", 1'b0, irq);
      $display("test idle status done");
   endtask

   task automatic t_irq;
      rd_chk(`TPCR_IDX_IRQ_STAT, 32'h00000003);
      wr(`TPCR_IDX_IRQ_MASK, 32'h00000001);
      rd_chk(`TPCR_IDX_IRQ_MASK, 32'h00000001);
      drive(3'b100);
      drive(3'b000);
      settle(3);
      `CHK("irq", 1'b1, irq);
      drive(3'b010);
      drive(3'b000);
      settle(3);
      rd_chk(`TPCR_IDX_IRQ_STAT, 32'h00000003);
      settle(2);
      `CHK("irq", 1'b0, irq);
      drive(3'b010);
      drive(3'b000);
      settle(3);
      `CHK("irq", 1'b0, irq);
      rd_chk(`TPCR_IDX_IRQ_STAT, 32'h00000002);
      $display("test interrupt done");
   endtask

   // Mid-run reset in the smaller package: the receive-bit-three strap must win.
   task automatic t_strap;
      @(posedge pclk);
      package_36_pin <= 1'b0;
      presetn        <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(`TPCR_IDX_ROLE, 32'h00008000);
      `CHK("role", 1'b0, link_role_select);
      rd_chk(`TPCR_IDX_CTRL1, 32'h00000400);
      $display("test strap done");
   endtask

   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      lpi_in = '0;
      miscompares = 0;
      n_compared = 0;
      n_srst = 0;
      package_36_pin = 1'b1;
      indicator_zero_strap = 1'b1;
      receive_bit_three_strap = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_role();
      t_test();
      t_soft();
      t_lpi();
      t_irq();
      t_strap();
      stop_test();
   end
endmodule // tpcr_regs_tb

// file: verification/tpcr_sme_model.sv
// APB master model standing in for the station management entity.
// Assumes the register bank's pclk and presetn; the bench calls task xfer.
`timescale 1ns/100ps

module tpcr_sme_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB master
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [15:0] paddr,
   output      logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 16'h0000;
      pwdata  = 32'h00000000;
   end

   // One transfer; ok stays low if no answer comes within the bound.
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err, output logic ok);
      ok = 1'b0;
      rd = 32'h00000000;
      err = 1'b0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 16 && ok == 1'b0; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) begin
            ok  = 1'b1;
            rd  = prdata;
            err = pslverr;
         end
      end
      // Released address and write data show the inverse so a stale value never looks valid.
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~wd;
   endtask
endmodule // tpcr_sme_model

// file: verilog/tpcr_defines.svh
// Constants of the PMA/PCS control and status register bank.
// Assumes 32-bit APB data; each register sits in one aligned word at four times its index.
`ifndef TPCR_DEFINES_SVH
`define TPCR_DEFINES_SVH

// ****************************************************************
// Register indexes; byte address is four times the index
// ****************************************************************
`define TPCR_IDX_ROLE       14'h1834
`define TPCR_IDX_TEST       14'h1836
`define TPCR_IDX_CTRL1      14'h3000
`define TPCR_IDX_STAT1      14'h3001
`define TPCR_IDX_IRQ_STAT   14'h3010
`define TPCR_IDX_IRQ_MASK   14'h3011

// ****************************************************************
// Field positions
// ****************************************************************
`define TPCR_ROLE_MANUAL    15
`define TPCR_ROLE_SEL       14
`define TPCR_TEST_HI        15
`define TPCR_TEST_LO        13
`define TPCR_CTRL_SOFT_RST  15
`define TPCR_CTRL_LOOP      14
`define TPCR_CTRL_RXSTOP    10
`define TPCR_STAT_TX_LATCH  11
`define TPCR_STAT_RX_LATCH  10
`define TPCR_STAT_TX_NOW    9
`define TPCR_STAT_RX_NOW    8
`define TPCR_STAT_TXSTOP    6
`define TPCR_EV_TX          0
`define TPCR_EV_RX          1

// ****************************************************************
// Reset values and the read-only type code
// ****************************************************************
`define TPCR_RST_TEST       16'h0000
`define TPCR_RST_RXSTOP     1'h1
`define TPCR_RST_MASK       2'h0
`define TPCR_TYPE_T1        4'h0

`endif

// file: verilog/tpcr_pkg.sv
// Types shared by the PMA/PCS control and status register bank.
// Assumes the constants of tpcr_defines.svh.
package tpcr_pkg;

   // Live low-power-idle conditions from the coding sublayer.
   typedef struct packed {
      logic transmit_idle_now;
      logic receive_idle_now;
      logic tx_clock_stoppable;
   } tpcr_lpi_in_type;

   // Test mode codes.
   typedef enum logic [2:0] {
      TPCR_TM_NORMAL = 3'h0,
      TPCR_TM_ONE    = 3'h1,
      TPCR_TM_TWO    = 3'h2,
      TPCR_TM_FOUR   = 3'h4,
      TPCR_TM_FIVE   = 3'h5
   } tpcr_test_mode_type;

   // Whole state of the register bank.
   typedef struct packed {
      logic        strap_done;
      logic        link_role_select;
      logic [15:0] test;
      logic        soft_reset;
      logic        loop_enable;
      logic        rx_stoppable;
      logic        tx_seen_latched;
      logic        rx_seen_latched;
      logic        tx_prev;
      logic        rx_prev;
      logic [1:0]  ev;
      logic [1:0]  mask;
      logic [2:0]  test_mode;
      logic        rx_stop_ok;
      logic        irq;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } tpcr_state_type;

endpackage

// file: verilog/tpcr_regs.sv
// PMA/PCS control and status registers of a single-pair PHY, reached over APB.
// Assumes one clock pclk, asynchronous active-low presetn and synchronous inputs.
`timescale 1ns/100ps
`include "tpcr_defines.svh"

module tpcr_regs (
   // Clock and reset
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   // APB slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [15:0]               paddr,
   input  wire logic [31:0]               pwdata,
   output      logic [31:0]               prdata,
   output      logic                      pready,
   output      logic                      pslverr,
   // Straps
   input  wire logic                      package_36_pin,
   input  wire logic                      indicator_zero_strap,
   input  wire logic                      receive_bit_three_strap,
   // Coding sublayer conditions
   input  wire tpcr_pkg::tpcr_lpi_in_type lpi_in,
   // Controls
   output      logic                      link_role_select,
   output      logic [2:0]                test_mode_select,
   output      logic                      coding_sublayer_soft_reset,
   output      logic                      coding_sublayer_loop_enable,
   output      logic                      receive_clock_stop_allowed,
   // Interrupt
   output      logic                      irq
);

   // ****************************************************************
   // Functions
   // ****************************************************************
   function automatic logic [2:0] decode_test(input logic [2:0] code);
      case (code)
         3'h1, 3'h2, 3'h4, 3'h5: decode_test = code;
         default:                decode_test = 3'h0;
      endcase
   endfunction

   function automatic logic is_mapped(input logic [13:0] idx);
      is_mapped = (idx == `TPCR_IDX_ROLE) || (idx == `TPCR_IDX_TEST) ||
                  (idx == `TPCR_IDX_CTRL1) || (idx == `TPCR_IDX_STAT1) ||
                  (idx == `TPCR_IDX_IRQ_STAT) || (idx == `TPCR_IDX_IRQ_MASK);
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   tpcr_pkg::tpcr_state_type q;
   tpcr_pkg::tpcr_state_type d;
   logic [13:0]              idx;
   logic                     setup;
   logic                     acc;
   logic                     wr;
   logic                     rd;
   logic                     strap_pick;
   logic [15:0]              rdata;
   logic                     clr_stat;
   logic                     clr_irq;

   assign idx        = paddr[15:2];
   assign setup      = psel & ~penable;
   assign acc        = psel & penable & q.pready;
   assign wr         = acc & pwrite & ~q.pslverr;
   assign rd         = acc & ~pwrite & ~q.pslverr;
   assign strap_pick = package_36_pin ? indicator_zero_strap : receive_bit_three_strap;
   assign clr_stat   = rd & (idx == `TPCR_IDX_STAT1);
   assign clr_irq    = rd & (idx == `TPCR_IDX_IRQ_STAT);

   // ****************************************************************
   // Read multiplexer
   // ****************************************************************
   always_comb begin
      rdata = 16'h0000;
      case (idx)
         `TPCR_IDX_ROLE: begin
            rdata[`TPCR_ROLE_MANUAL] = 1'b1;
            rdata[`TPCR_ROLE_SEL]    = q.link_role_select;
            rdata[3:0]               = `TPCR_TYPE_T1;
         end
         `TPCR_IDX_TEST: begin
            rdata = q.test;
         end
         `TPCR_IDX_CTRL1: begin
            rdata[`TPCR_CTRL_SOFT_RST] = q.soft_reset;
            rdata[`TPCR_CTRL_LOOP]     = q.loop_enable;
            rdata[`TPCR_CTRL_RXSTOP]   = q.rx_stoppable;
         end
         `TPCR_IDX_STAT1: begin
            rdata[`TPCR_STAT_TX_LATCH] = q.tx_seen_latched;
            rdata[`TPCR_STAT_RX_LATCH] = q.rx_seen_latched;
            rdata[`TPCR_STAT_TX_NOW]   = lpi_in.transmit_idle_now;
            rdata[`TPCR_STAT_RX_NOW]   = lpi_in.receive_idle_now;
            rdata[`TPCR_STAT_TXSTOP]   = lpi_in.tx_clock_stoppable;
         end
         `TPCR_IDX_IRQ_STAT: begin
            rdata[1:0] = q.ev;
         end
         `TPCR_IDX_IRQ_MASK: begin
            rdata[1:0] = q.mask;
         end
         default: begin
            rdata = 16'h0000;
         end
      endcase
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      d = q;
      // APB answers one cycle after setup, so every access takes two cycles.
      d.pready  = setup;
      d.pslverr = setup & ~is_mapped(idx);
      if (setup) begin
         d.prdata = {16'h0000, rdata};
      end

      // The strap is caught on the first edge after reset release.
      if (!q.strap_done) begin
         d.strap_done       = 1'b1;
         d.link_role_select = strap_pick;
      end

      d.soft_reset = 1'b0;
      if (wr) begin
         case (idx)
            `TPCR_IDX_ROLE: begin
               d.link_role_select = pwdata[`TPCR_ROLE_SEL];
            end
            `TPCR_IDX_TEST: begin
               d.test = pwdata[15:0];
            end
            `TPCR_IDX_CTRL1: begin
               d.loop_enable  = pwdata[`TPCR_CTRL_LOOP];
               d.rx_stoppable = pwdata[`TPCR_CTRL_RXSTOP];
               d.soft_reset   = pwdata[`TPCR_CTRL_SOFT_RST];
            end
            `TPCR_IDX_IRQ_MASK: begin
               d.mask = pwdata[1:0];
            end
            default: begin
               d.mask = d.mask;
            end
         endcase
      end

      // The soft reset returns the control 1 and status 1 registers to their reset values.
      if (q.soft_reset) begin
         d.loop_enable     = 1'b0;
         d.rx_stoppable    = `TPCR_RST_RXSTOP;
         d.tx_seen_latched = 1'b0;
         d.rx_seen_latched = 1'b0;
      end

      // Only bits that were returned are cleared, so an event arriving between
      // setup and access survives; a set in the clearing cycle wins.
      if (clr_stat) begin
         d.tx_seen_latched = q.tx_seen_latched & ~q.prdata[`TPCR_STAT_TX_LATCH];
         d.rx_seen_latched = q.rx_seen_latched & ~q.prdata[`TPCR_STAT_RX_LATCH];
      end
      if (lpi_in.transmit_idle_now) begin
         d.tx_seen_latched = 1'b1;
      end
      if (lpi_in.receive_idle_now) begin
         d.rx_seen_latched = 1'b1;
      end

      // Interrupt events are rising edges of the idle conditions.
      d.tx_prev = lpi_in.transmit_idle_now;
      d.rx_prev = lpi_in.receive_idle_now;
      if (clr_irq) begin
         d.ev = q.ev & ~q.prdata[1:0];
      end
      d.ev[`TPCR_EV_TX] = d.ev[`TPCR_EV_TX] | (lpi_in.transmit_idle_now & ~q.tx_prev);
      d.ev[`TPCR_EV_RX] = d.ev[`TPCR_EV_RX] | (lpi_in.receive_idle_now & ~q.rx_prev);
      d.irq = |(d.ev & d.mask);

      d.test_mode  = decode_test(q.test[`TPCR_TEST_HI:`TPCR_TEST_LO]);
      d.rx_stop_ok = q.rx_stoppable & lpi_in.receive_idle_now;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q              <= '0;
         q.test         <= `TPCR_RST_TEST;
         q.rx_stoppable <= `TPCR_RST_RXSTOP;
         q.mask         <= `TPCR_RST_MASK;
      end else begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign prdata                      = q.prdata;
   assign pready                      = q.pready;
   assign pslverr                     = q.pslverr;
   assign link_role_select            = q.link_role_select;
   assign test_mode_select            = q.test_mode;
   assign coding_sublayer_soft_reset  = q.soft_reset;
   assign coding_sublayer_loop_enable = q.loop_enable;
   assign receive_clock_stop_allowed  = q.rx_stop_ok;
   assign irq                         = q.irq;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic rd_setup_role;
   logic rd_setup_stat;
   assign rd_setup_role = setup & ~pwrite & (idx == `TPCR_IDX_ROLE);
   assign rd_setup_stat = setup & ~pwrite & (idx == `TPCR_IDX_STAT1);

   chk_role_write: assert property (
      wr && idx == `TPCR_IDX_ROLE |=> link_role_select == $past(pwdata[14]))
      else $error("role select not taken from write");

   chk_strap_load: assert property (
      $rose(q.strap_done) |-> link_role_select == $past(strap_pick))
      else $error("role select not loaded from strap");

   chk_role_read: assert property (
      rd_setup_role |=> prdata[3:0] == 4'h0 && prdata[15] == 1'b1)
      else $error("role register type or manual bit wrong");

   chk_test_reserved: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h3 |=> ##1 test_mode_select == 3'h0)
      else $error("reserved test code not treated as normal");

   chk_soft_pulse: assert property (
      wr && idx == `TPCR_IDX_CTRL1 && pwdata[15] |=> coding_sublayer_soft_reset ##1
      !coding_sublayer_soft_reset)
      else $error("soft reset not a single self-clearing pulse");

   chk_loop_clear: assert property (
      coding_sublayer_soft_reset |=> !coding_sublayer_loop_enable && q.rx_stoppable)
      else $error("soft reset did not clear loop enable");

   chk_rx_stop: assert property (
      receive_clock_stop_allowed |-> $past(q.rx_stoppable) && $past(lpi_in.receive_idle_now))
      else $error("receive clock stop allowed without permission");

   chk_tx_latch: assert property (
      lpi_in.transmit_idle_now |=> q.tx_seen_latched)
      else $error("transmit idle not latched");

   chk_rx_latch: assert property (
      lpi_in.receive_idle_now |=> q.rx_seen_latched)
      else $error("receive idle not latched");

   chk_live_status: assert property (
      rd_setup_stat |=> prdata[9] == $past(lpi_in.transmit_idle_now) &&
      prdata[8] == $past(lpi_in.receive_idle_now) &&
      prdata[6] == $past(lpi_in.tx_clock_stoppable))
      else $error("live status bits wrong");

   chk_read_clear: assert property (
      clr_stat && q.prdata[11] && !lpi_in.transmit_idle_now |=> !q.tx_seen_latched)
      else $error("latched transmit idle not cleared by read");

   chk_rx_clear: assert property (
      clr_stat && q.prdata[10] && !lpi_in.receive_idle_now |=> !q.rx_seen_latched)
      else $error("latched receive idle not cleared by read");

   // A latch that drops without a read would hide an idle period from software.
   chk_tx_hold: assert property (
      q.tx_seen_latched && !clr_stat && !q.soft_reset |=> q.tx_seen_latched)
      else $error("latched transmit idle dropped without a read");

   chk_rx_hold: assert property (
      q.rx_seen_latched && !clr_stat && !q.soft_reset |=> q.rx_seen_latched)
      else $error("latched receive idle dropped without a read");

   chk_role_hold: assert property (
      q.strap_done && !(wr && idx == `TPCR_IDX_ROLE) |=> $stable(link_role_select))
      else $error("role select changed without a write");

   chk_soft_idle: assert property (
      !(wr && idx == `TPCR_IDX_CTRL1 && pwdata[15]) |=> !coding_sublayer_soft_reset)
      else $error("soft reset pulsed without a write");

   chk_test_normal: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h0 |=> ##1 test_mode_select == 3'h0)
      else $error("normal test code not decoded");

   chk_test_one: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h1 |=> ##1 test_mode_select == 3'h1)
      else $error("test mode one not decoded");

   chk_test_two: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h2 |=> ##1 test_mode_select == 3'h2)
      else $error("test mode two not decoded");

   chk_test_four: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h4 |=> ##1 test_mode_select == 3'h4)
      else $error("test mode four not decoded");

   chk_test_five: assert property (
      wr && idx == `TPCR_IDX_TEST && pwdata[15:13] == 3'h5 |=> ##1 test_mode_select == 3'h5)
      else $error("test mode five not decoded");

   chk_perm_write: assert property (
      wr && idx == `TPCR_IDX_CTRL1 |=> q.rx_stoppable == $past(pwdata[10]))
      else $error("receive clock stop permission not taken from write");

   chk_rx_stop_on: assert property (
      q.rx_stoppable && lpi_in.receive_idle_now |=> receive_clock_stop_allowed)
      else $error("receive clock stop withheld despite permission");

   cov_soft_reset: cover property (coding_sublayer_soft_reset);
   cov_latch_read: cover property (clr_stat && q.prdata[11]);
   cov_test_five: cover property (test_mode_select == 3'h5);
   cov_irq: cover property ($rose(irq));
   cov_strap_slave: cover property ($rose(q.strap_done) && !link_role_select);

endmodule // tpcr_regs
